// >>> design/hptw_walker.sv
`timescale 1ns/1ps
// Notes on behaviour
// - On a lookaside miss, search the hashed table in memory for the entry.
// - Primary hash is segment id XOR effective address page index.
// - Table reads use real addressing, relocation off, coherence required.
// - A group is eight entries of eight bytes, 64 bytes in all.
// - Sixteen candidate slots over two groups; miss in both is a page fault.
// - Primary hash joined with register base bits gives primary group address.
// - Entries in a group are examined one at a time until match or eight.
// - No primary match: form secondary address and search that group.
// - Base register: origin high sixteen, reserved middle, index mask low nine.
// - Origin gives upper sixteen address bits; table on 64 KB boundary.
// - Table sizes two to the sixteen up to two to the twenty-five.
// - Each mask one admits one more hash bit beyond the ten always used.
// - Secondary hash is one's complement of primary hash.
// - Hash inputs are low 19 segment id bits and zero-extended page index.
// - Miss in both groups raises a fault so software can install entry.
module hptw_walker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [hptw_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic miss_valid,
	input wire logic [hptw_pkg::VIRTUAL_SEGMENT_ID_W-1:0] miss_virtual_segment_id,
	input wire logic [hptw_pkg::PIDX_W-1:0] miss_page_index,
	output logic miss_ready,
	output logic done_valid,
	output logic done_hit,
	output logic done_fault,
	output logic done_secondary,
	output logic [63:0] done_entry,
	output logic mem_rd_req,
	output logic [31:0] mem_rd_addr,
	output logic mem_coherent,
	output logic data_relocate_enable,
	input wire logic mem_rd_ack,
	input wire logic [63:0] mem_rd_data
);
	typedef enum logic [1:0] {
		HPTW_IDLE,
		HPTW_FETCH,
		HPTW_CHECK,
		HPTW_DONE
	} hptw_state_t;

	hptw_state_t state_ff;
	hptw_state_t nxt_state;
	logic [31:0] base_size_ff;
	logic [31:0] nxt_base_size;
	logic [hptw_pkg::VIRTUAL_SEGMENT_ID_W-1:0] virtual_segment_id_ff;
	logic [hptw_pkg::VIRTUAL_SEGMENT_ID_W-1:0] nxt_virtual_segment_id;
	logic [hptw_pkg::PIDX_W-1:0] pidx_ff;
	logic [hptw_pkg::PIDX_W-1:0] nxt_pidx;
	logic [31:0] sec_addr_ff;
	logic [31:0] nxt_sec_addr;
	logic [31:0] group_addr_ff;
	logic [31:0] nxt_group_addr;
	logic [hptw_pkg::SLOT_W-1:0] slot_ff;
	logic [hptw_pkg::SLOT_W-1:0] nxt_slot;
	logic secondary_ff;
	logic nxt_secondary;
	logic [63:0] entry_ff;
	logic [63:0] nxt_entry;
	logic mem_rd_req_ff;
	logic nxt_mem_rd_req;
	logic [31:0] mem_rd_addr_ff;
	logic [31:0] nxt_mem_rd_addr;
	logic mem_coherent_ff;
	logic nxt_mem_coherent;
	logic miss_ready_ff;
	logic nxt_miss_ready;
	logic done_valid_ff;
	logic nxt_done_valid;
	logic done_hit_ff;
	logic nxt_done_hit;
	logic done_fault_ff;
	logic nxt_done_fault;
	logic done_secondary_ff;
	logic nxt_done_secondary;
	logic [63:0] done_entry_ff;
	logic [63:0] nxt_done_entry;
	logic [hptw_pkg::SLOT_W-1:0] hit_slot_ff;
	logic [hptw_pkg::SLOT_W-1:0] nxt_hit_slot;
	logic [31:0] fault_cnt_ff;
	logic [31:0] nxt_fault_cnt;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic pready_ff;
	logic nxt_pready;
	logic pslverr_ff;
	logic nxt_pslverr;
	logic [31:0] prim_addr;
	logic [31:0] scnd_addr;
	logic apb_access;
	logic apb_commit;
	logic addr_mapped;
	logic [31:0] status_word;

	hptw_group_addr u_group_addr (
		.virtual_segment_id(miss_virtual_segment_id),
		.page_index(miss_page_index),
		.base_size(base_size_ff),
		.primary_addr(prim_addr),
		.secondary_addr(scnd_addr)
	);

	// Search sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_virtual_segment_id = virtual_segment_id_ff;
		nxt_pidx = pidx_ff;
		nxt_sec_addr = sec_addr_ff;
		nxt_group_addr = group_addr_ff;
		nxt_slot = slot_ff;
		nxt_secondary = secondary_ff;
		nxt_entry = entry_ff;
		nxt_mem_rd_req = mem_rd_req_ff;
		nxt_mem_rd_addr = mem_rd_addr_ff;
		nxt_mem_coherent = mem_coherent_ff;
		nxt_miss_ready = miss_ready_ff;
		nxt_done_valid = 1'b0;
		nxt_done_hit = done_hit_ff;
		nxt_done_fault = done_fault_ff;
		nxt_done_secondary = done_secondary_ff;
		nxt_done_entry = done_entry_ff;
		nxt_hit_slot = hit_slot_ff;
		nxt_fault_cnt = fault_cnt_ff;
		unique case (state_ff)
			HPTW_IDLE: begin
				if (miss_valid && miss_ready_ff) begin
					nxt_virtual_segment_id = miss_virtual_segment_id;
					nxt_pidx = miss_page_index;
					nxt_group_addr = prim_addr;
					nxt_sec_addr = scnd_addr;
					nxt_slot = '0;
					nxt_secondary = 1'b0;
					nxt_mem_rd_req = 1'b1;
					nxt_mem_rd_addr = prim_addr;
					nxt_mem_coherent = 1'b1;
					nxt_miss_ready = 1'b0;
					nxt_state = HPTW_FETCH;
				end
			end
			HPTW_FETCH: begin
				if (mem_rd_ack) begin
					nxt_entry = mem_rd_data;
					nxt_mem_rd_req = 1'b0;
					nxt_mem_coherent = 1'b0;
					nxt_state = HPTW_CHECK;
				end
			end
			HPTW_CHECK: begin
				if (hptw_pkg::entry_matches(entry_ff, virtual_segment_id_ff, pidx_ff, secondary_ff)) begin
					nxt_done_hit = 1'b1;
					nxt_done_fault = 1'b0;
					nxt_done_secondary = secondary_ff;
					nxt_done_entry = entry_ff;
					nxt_hit_slot = slot_ff;
					nxt_done_valid = 1'b1;
					nxt_state = HPTW_DONE;
				end else if (slot_ff != hptw_pkg::LAST_SLOT) begin
					nxt_slot = slot_ff + 1'b1;
					nxt_mem_rd_req = 1'b1;
					nxt_mem_rd_addr = group_addr_ff +
						32'(({29'h0, slot_ff} + 32'h1) * hptw_pkg::ENTRY_BYTES);
					nxt_mem_coherent = 1'b1;
					nxt_state = HPTW_FETCH;
				end else if (!secondary_ff) begin
					nxt_secondary = 1'b1;
					nxt_group_addr = sec_addr_ff;
					nxt_slot = '0;
					nxt_mem_rd_req = 1'b1;
					nxt_mem_rd_addr = sec_addr_ff;
					nxt_mem_coherent = 1'b1;
					nxt_state = HPTW_FETCH;
				end else begin
					nxt_done_hit = 1'b0;
					nxt_done_fault = 1'b1;
					nxt_done_secondary = 1'b1;
					nxt_done_entry = '0;
					nxt_hit_slot = '0;
					nxt_fault_cnt = fault_cnt_ff + 32'h1;
					nxt_done_valid = 1'b1;
					nxt_state = HPTW_DONE;
				end
			end
			HPTW_DONE: begin
				nxt_miss_ready = 1'b1;
				nxt_state = HPTW_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= HPTW_IDLE;
			virtual_segment_id_ff <= '0;
			pidx_ff <= '0;
			sec_addr_ff <= '0;
			group_addr_ff <= '0;
			slot_ff <= '0;
			secondary_ff <= 1'b0;
			entry_ff <= '0;
			mem_rd_req_ff <= 1'b0;
			mem_rd_addr_ff <= '0;
			mem_coherent_ff <= 1'b0;
			miss_ready_ff <= 1'b1;
			done_valid_ff <= 1'b0;
			done_hit_ff <= 1'b0;
			done_fault_ff <= 1'b0;
			done_secondary_ff <= 1'b0;
			done_entry_ff <= '0;
			hit_slot_ff <= '0;
			fault_cnt_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			virtual_segment_id_ff <= nxt_virtual_segment_id;
			pidx_ff <= nxt_pidx;
			sec_addr_ff <= nxt_sec_addr;
			group_addr_ff <= nxt_group_addr;
			slot_ff <= nxt_slot;
			secondary_ff <= nxt_secondary;
			entry_ff <= nxt_entry;
			mem_rd_req_ff <= nxt_mem_rd_req;
			mem_rd_addr_ff <= nxt_mem_rd_addr;
			mem_coherent_ff <= nxt_mem_coherent;
			miss_ready_ff <= nxt_miss_ready;
			done_valid_ff <= nxt_done_valid;
			done_hit_ff <= nxt_done_hit;
			done_fault_ff <= nxt_done_fault;
			done_secondary_ff <= nxt_done_secondary;
			done_entry_ff <= nxt_done_entry;
			hit_slot_ff <= nxt_hit_slot;
			fault_cnt_ff <= nxt_fault_cnt;
		end
	end

	// APB slave, one wait state
	always_comb begin
		apb_access = psel && penable;
		apb_commit = apb_access && pready_ff;
		addr_mapped = (paddr == hptw_pkg::OFF_BASE_SIZE) || (paddr == hptw_pkg::OFF_STATUS) ||
			(paddr == hptw_pkg::OFF_ENTRY_LO) || (paddr == hptw_pkg::OFF_ENTRY_HI) ||
			(paddr == hptw_pkg::OFF_FAULT_CNT);
		status_word = '0;
		status_word[hptw_pkg::ST_BUSY] = (state_ff != HPTW_IDLE);
		status_word[hptw_pkg::ST_HIT] = done_hit_ff;
		status_word[hptw_pkg::ST_FAULT] = done_fault_ff;
		status_word[hptw_pkg::ST_SECONDARY] = done_secondary_ff;
		status_word[hptw_pkg::ST_SLOT_LSB +: hptw_pkg::SLOT_W] = hit_slot_ff;
		nxt_pready = apb_access && !pready_ff;
		nxt_pslverr = 1'b0;
		nxt_prdata = '0;
		nxt_base_size = base_size_ff;
		if (apb_access && !pready_ff) begin
			nxt_pslverr = !addr_mapped;
			if (!pwrite) begin
				unique case (paddr)
					hptw_pkg::OFF_BASE_SIZE: nxt_prdata = base_size_ff;
					hptw_pkg::OFF_STATUS: nxt_prdata = status_word;
					hptw_pkg::OFF_ENTRY_LO: nxt_prdata = done_entry_ff[31:0];
					hptw_pkg::OFF_ENTRY_HI: nxt_prdata = done_entry_ff[63:32];
					hptw_pkg::OFF_FAULT_CNT: nxt_prdata = fault_cnt_ff;
					default: nxt_prdata = '0;
				endcase
			end
		end
		if (apb_commit && pwrite && (paddr == hptw_pkg::OFF_BASE_SIZE)) begin
			nxt_base_size = pwdata & hptw_pkg::BASE_SIZE_WMASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_size_ff <= hptw_pkg::BASE_SIZE_RST;
			prdata_ff <= '0;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			base_size_ff <= nxt_base_size;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	// Table reads never relocate
	logic relocate_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			relocate_ff <= 1'b0;
		end else begin
			relocate_ff <= 1'b0;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign miss_ready = miss_ready_ff;
	assign done_valid = done_valid_ff;
	assign done_hit = done_hit_ff;
	assign done_fault = done_fault_ff;
	assign done_secondary = done_secondary_ff;
	assign done_entry = done_entry_ff;
	assign mem_rd_req = mem_rd_req_ff;
	assign mem_rd_addr = mem_rd_addr_ff;
	assign mem_coherent = mem_coherent_ff;
	assign data_relocate_enable = relocate_ff;
endmodule

// >>> include/hptw_pkg.sv
package hptw_pkg;
	// Register map, byte addresses on APB
	localparam logic [11:0] OFF_BASE_SIZE = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_ENTRY_LO = 12'h008;
	localparam logic [11:0] OFF_ENTRY_HI = 12'h00C;
	localparam logic [11:0] OFF_FAULT_CNT = 12'h010;
	localparam int ADDR_W = 12;

	// Base-and-size layout, little-endian numbering
	localparam int ORIGIN_LSB = 16;
	localparam int ORIGIN_W = 16;
	localparam int MASK_LSB = 0;
	localparam int MASK_W = 9;
	localparam logic [31:0] BASE_SIZE_WMASK = 32'hFFFF01FF;
	localparam logic [31:0] BASE_SIZE_RST = 32'h00000000;

	// Hash
	localparam int HASH_W = 19;
	localparam int PIDX_W = 16;
	localparam int VIRTUAL_SEGMENT_ID_W = 24;
	localparam int HASH_MIN_BITS = 10;
	localparam int GROUP_OFS_BITS = 6;
	localparam int ENTRY_BYTES = 8;
	localparam int SLOTS = 8;
	localparam int SLOT_W = 3;
	localparam logic [SLOT_W-1:0] LAST_SLOT = 3'h7;

	// Translation entry layout
	localparam int TE_VALID = 63;
	localparam int TE_VIRTUAL_SEGMENT_ID_LSB = 39;
	localparam int TE_HSEL = 38;
	localparam int TE_API_LSB = 32;
	localparam int API_W = 6;

	// Status bits
	localparam int ST_BUSY = 0;
	localparam int ST_HIT = 1;
	localparam int ST_FAULT = 2;
	localparam int ST_SECONDARY = 3;
	localparam int ST_SLOT_LSB = 4;

	function automatic logic entry_matches(
		input logic [63:0] entry,
		input logic [VIRTUAL_SEGMENT_ID_W-1:0] virtual_segment_id,
		input logic [PIDX_W-1:0] pidx,
		input logic secondary
	);
		entry_matches = entry[TE_VALID] &&
			(entry[TE_VIRTUAL_SEGMENT_ID_LSB +: VIRTUAL_SEGMENT_ID_W] == virtual_segment_id) &&
			(entry[TE_HSEL] == secondary) &&
			(entry[TE_API_LSB +: API_W] == pidx[PIDX_W-1 -: API_W]);
	endfunction
endpackage

// >>> design/hptw_group_addr.sv
`timescale 1ns/1ps
module hptw_group_addr (
	input wire logic [hptw_pkg::VIRTUAL_SEGMENT_ID_W-1:0] virtual_segment_id,
	input wire logic [hptw_pkg::PIDX_W-1:0] page_index,
	input wire logic [31:0] base_size,
	output logic [31:0] primary_addr,
	output logic [31:0] secondary_addr
);
	logic [hptw_pkg::HASH_W-1:0] hash1;
	logic [hptw_pkg::HASH_W-1:0] hash2;
	logic [hptw_pkg::ORIGIN_W-1:0] origin;
	logic [hptw_pkg::MASK_W-1:0] mask;

	function automatic logic [31:0] form_addr(
		input logic [hptw_pkg::HASH_W-1:0] h,
		input logic [hptw_pkg::ORIGIN_W-1:0] org,
		input logic [hptw_pkg::MASK_W-1:0] msk
	);
		logic [hptw_pkg::MASK_W-1:0] upper;
		upper = org[hptw_pkg::MASK_W-1:0] | (h[hptw_pkg::HASH_W-1 -: hptw_pkg::MASK_W] & msk);
		form_addr = {org[hptw_pkg::ORIGIN_W-1:hptw_pkg::MASK_W], upper,
			h[hptw_pkg::HASH_MIN_BITS-1:0], {hptw_pkg::GROUP_OFS_BITS{1'b0}}};
	endfunction

	always_comb begin
		origin = base_size[hptw_pkg::ORIGIN_LSB +: hptw_pkg::ORIGIN_W];
		mask = base_size[hptw_pkg::MASK_LSB +: hptw_pkg::MASK_W];
		hash1 = virtual_segment_id[hptw_pkg::HASH_W-1:0] ^ {3'h0, page_index};
		hash2 = ~hash1;
		primary_addr = form_addr(hash1, origin, mask);
		secondary_addr = form_addr(hash2, origin, mask);
	end
endmodule

// >>> dv/hptw_checks_assertions.sv
`timescale 1ns/1ps
module hptw_checks (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic miss_valid,
	input wire logic miss_ready,
	input wire logic done_valid,
	input wire logic done_hit,
	input wire logic done_fault,
	input wire logic done_secondary,
	input wire logic [63:0] done_entry,
	input wire logic mem_rd_req,
	input wire logic [31:0] mem_rd_addr,
	input wire logic mem_coherent,
	input wire logic data_relocate_enable,
	input wire logic mem_rd_ack
);
	logic [4:0] cnt_ff, nxt_cnt;
	logic [31:0] last_ff, nxt_last;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Reads acknowledged since the request was taken, and the last address read
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_last = last_ff;
		if (miss_valid && miss_ready) nxt_cnt = 5'h00;
		if (mem_rd_req && mem_rd_ack) begin
			nxt_cnt = cnt_ff + 5'h01;
			nxt_last = mem_rd_addr;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 5'h00;
			last_ff <= 32'h0;
		end else begin
			cnt_ff <= nxt_cnt;
			last_ff <= nxt_last;
		end
	end
	sequence taken_s;
		miss_valid && miss_ready;
	endsequence
	sequence read_s;
		!miss_ready && mem_rd_req;
	endsequence
	start_read_a: assert property (taken_s |=> read_s)
		else $error("no read after request");
	coherent_a: assert property (mem_coherent == mem_rd_req)
		else $error("coherent flag wrong");
	reloc_off_a: assert property (!data_relocate_enable)
		else $error("relocation on");
	entry_align_a: assert property (mem_rd_req |-> mem_rd_addr[2:0] == 3'h0)
		else $error("read address unaligned");
	read_hold_a: assert property (mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr))
		else $error("read dropped early");
	next_slot_a: assert property ($rose(mem_rd_req) && cnt_ff[2:0] != 3'h0 |-> mem_rd_addr == last_ff + 32'h8)
		else $error("slot step wrong");
	done_once_a: assert property (done_valid |=> !done_valid && miss_ready)
		else $error("done not one pulse");
	fault_reads_a: assert property (done_valid && done_fault |-> cnt_ff == 5'h10 && done_entry == 64'h0 && !done_hit)
		else $error("fault without sixteen reads");
	which_group_a: assert property (done_valid && done_hit |-> done_secondary == (cnt_ff > 5'h08) && !done_fault)
		else $error("group flag wrong");
endmodule

// >>> dv/hptw_mem_model.sv
`timescale 1ns/1ps
module hptw_mem_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic mem_rd_req,
	input wire logic [31:0] mem_rd_addr,
	input wire logic mem_coherent,
	input wire logic [3:0] lat,
	output logic mem_rd_ack,
	output logic [63:0] mem_rd_data
);
	logic [63:0] store [logic [31:0]];
	logic [3:0] wait_ff;
	logic [63:0] last_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_ff <= 4'h0;
			last_ff <= 64'h0;
		end else begin
			wait_ff <= (mem_rd_req && !mem_rd_ack) ? wait_ff + 4'h1 : 4'h0;
			if (mem_rd_ack) last_ff <= mem_rd_data;
		end
	end
	// Answers only coherent reads; data lines wander when not answering
	always_comb begin
		mem_rd_ack = mem_rd_req && mem_coherent && wait_ff >= lat;
		mem_rd_data = ~last_ff;
		if (mem_rd_ack) mem_rd_data = store.exists(mem_rd_addr) ? store[mem_rd_addr] : 64'h0;
	end
endmodule

// >>> dv/hptw_walker_tb.sv
`timescale 1ns/1ps
module hptw_walker_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, miss_valid, miss_ready;
	logic done_valid, done_hit, done_fault, done_secondary, mem_rd_req, mem_coherent, reloc, mem_rd_ack;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, mem_rd_addr, base;
	logic [23:0] miss_virtual_segment_id;
	logic [15:0] miss_page_index;
	logic [63:0] done_entry, mem_rd_data;
	logic [3:0] lat;
	int num_errors = 0;
	int comparisons = 0;
	hptw_walker hptw_walker_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.miss_valid(miss_valid), .miss_virtual_segment_id(miss_virtual_segment_id), .miss_page_index(miss_page_index),
		.miss_ready(miss_ready), .done_valid(done_valid), .done_hit(done_hit), .done_fault(done_fault),
		.done_secondary(done_secondary), .done_entry(done_entry), .mem_rd_req(mem_rd_req),
		.mem_rd_addr(mem_rd_addr), .mem_coherent(mem_coherent), .data_relocate_enable(reloc),
		.mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data));
	hptw_mem_model mem_i (.pclk(pclk), .presetn(presetn), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
		.mem_coherent(mem_coherent), .lat(lat), .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	function automatic logic [31:0] grp(logic [23:0] v, logic [15:0] p, logic [31:0] b, logic s);
		logic [18:0] h;
		h = v[18:0] ^ {3'h0, p};
		if (s) h = ~h;
		grp = {b[31:25], b[24:16] | (h[18:10] & b[8:0]), h[9:0], 6'h00};
	endfunction
	function automatic logic [63:0] ent(logic [23:0] v, logic [15:0] p, logic s);
		ent = {1'b1, v, s, p[15:10], 16'hA5A5, p};
	endfunction
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input string nm, input logic [31:0] m, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(nm, {32'h0, x}, {32'h0, q & m});
		chk("slverr", 64'h0, {63'h0, e});
	endtask
	task automatic setbase(input logic [31:0] b);
		logic [31:0] q;
		logic e;
		apb(1'b1, hptw_pkg::OFF_BASE_SIZE, b, q, e);
		base = b;
	endtask
	task automatic put(input logic [23:0] v, input logic [15:0] p, input logic s, input logic fs, input logic [2:0] k);
		mem_i.store[grp(v, p, base, s) + {26'h0, k, 3'h0}] = ent(v, p, fs);
	endtask
	task automatic search(input logic [23:0] v, input logic [15:0] p, input logic hit, input logic sec);
		@(posedge pclk);
		miss_valid <= 1'b1;
		miss_virtual_segment_id <= v;
		miss_page_index <= p;
		do begin
			@(posedge pclk);
		end while (miss_ready !== 1'b1);
		miss_valid <= 1'b0;
		do begin
			@(posedge pclk);
		end while (done_valid !== 1'b1);
		chk("hit", {63'h0, hit}, {63'h0, done_hit});
		chk("fault", {63'h0, ~hit}, {63'h0, done_fault});
		if (hit) chk("sec", {63'h0, sec}, {63'h0, done_secondary});
		chk("entry", hit ? ent(v, p, sec) : 64'h0, done_entry);
	endtask
	task automatic reg_scn();
		logic [31:0] q;
		logic e;
		rd(hptw_pkg::OFF_BASE_SIZE, "base rst", 32'hFFFFFFFF, 32'h0);
		setbase(32'hFFFFFFFF);
		rd(hptw_pkg::OFF_BASE_SIZE, "base rsvd", 32'hFFFFFFFF, 32'hFFFF01FF);
		apb(1'b0, 12'h014, 32'h0, q, e);
		chk("unmapped", 64'h1, {63'h0, e});
	endtask
	task automatic prim_scn();
		setbase(32'h00120000);
		put(24'h00ABCD, 16'h1234, 1'b0, 1'b0, 3'h0);
		lat <= 4'h0;
		search(24'h00ABCD, 16'h1234, 1'b1, 1'b0);
		search(24'h00ABCD, 16'h1234, 1'b1, 1'b0);
		rd(hptw_pkg::OFF_ENTRY_HI, "entry hi", 32'hFFFFFFFF, 32'h8055E684);
		rd(hptw_pkg::OFF_ENTRY_LO, "entry lo", 32'hFFFFFFFF, 32'hA5A51234);
		rd(hptw_pkg::OFF_STATUS, "status", 32'h0000007F, 32'h00000002);
	endtask
	task automatic sec_scn();
		setbase(32'h01240003);
		put(24'h05A5A5, 16'h0C3F, 1'b0, 1'b1, 3'h0);
		put(24'h05A5A5, 16'h0C3F, 1'b1, 1'b1, 3'h7);
		lat <= 4'h3;
		search(24'h05A5A5, 16'h0C3F, 1'b1, 1'b1);
		rd(hptw_pkg::OFF_STATUS, "status", 32'h0000007F, 32'h0000007A);
	endtask
	task automatic fault_scn();
		setbase(32'hFE0001FF);
		lat <= 4'h1;
		search(24'h123456, 16'hFFFF, 1'b0, 1'b0);
		rd(hptw_pkg::OFF_STATUS, "status", 32'h00000006, 32'h00000004);
		rd(hptw_pkg::OFF_FAULT_CNT, "faults", 32'hFFFFFFFF, 32'h00000001);
	endtask
	task automatic tally_and_finish();
		if (num_errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		miss_valid = 1'b0;
		miss_virtual_segment_id = 24'h0;
		miss_page_index = 16'h0;
		lat = 4'h0;
		base = 32'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		reg_scn();
		prim_scn();
		sec_scn();
		fault_scn();
		tally_and_finish();
	end
	initial begin
		repeat (5000) @(posedge pclk);
		num_errors++;
		tally_and_finish();
	end
endmodule
bind hptw_walker hptw_checks hptw_checks_i (.pclk(pclk), .presetn(presetn), .miss_valid(miss_valid),
	.miss_ready(miss_ready), .done_valid(done_valid), .done_hit(done_hit), .done_fault(done_fault),
	.done_secondary(done_secondary), .done_entry(done_entry), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
	.mem_coherent(mem_coherent), .data_relocate_enable(data_relocate_enable), .mem_rd_ack(mem_rd_ack));
